/* sfs_supervisor.sv */
/*
 * System fault supervisor: clock detector control, fatal interrupt flags with
 * recovery watchdog and shadow store, windowed watchdog, reset sequencing and
 * cause latch, peripheral clock gates and soft resets, Wishbone register file.
 * Assumes rst_i is the power-on reset and that pins are asynchronous.
 */
`timescale 1ns/1ps
`include "sfs_map.svh"

module sfs_supervisor #(
    parameter int NUM_PERIPH = 8,
    parameter int WARM_RST_CYC = `SFS_WARM_RST_CYC
) (
    // Clock and power-on reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Clock detector pins
    input wire logic osc_i,
    input wire logic ref_clk_i,
    // External warm reset request, active low
    input wire logic ext_warm_rst_n_i,
    // Status and reset outputs
    output logic error_status_o,
    output logic fatal_int_o,
    output logic wd_int_o,
    output logic warm_rst_o,
    // Peripheral controls
    output logic [NUM_PERIPH-1:0] periph_clk_en_o,
    output logic [NUM_PERIPH-1:0] periph_rst_o
);

    localparam logic [15:0] WARM_LAST = 16'(WARM_RST_CYC - 1);

    logic ack_reg;
    logic [31:0] dat_reg;
    logic [31:0] rdata;
    logic bus_req;
    logic wr_en;
    logic soft_rst;

    logic mcd_disable_reg;
    logic osc_off_reg;
    logic missing_sts_reg;
    logic missing;
    logic missing_d_reg;

    logic [`SFS_FLAG_W-1:0] flags_reg;
    logic [`SFS_FLAG_W-1:0] flag_set;
    logic [`SFS_FLAG_W-1:0] flag_clr;
    logic [`SFS_FLAG_W-1:0] shadow_reg;
    sfs_pkg::sfs_count_t rwd_prd_reg;
    sfs_pkg::sfs_count_t rwd_cnt_reg;
    logic rwd_expire;

    logic wd_int_sel_reg;
    logic wd_en_reg;
    sfs_pkg::sfs_count_t wd_lo_reg;
    sfs_pkg::sfs_count_t wd_hi_reg;
    sfs_pkg::sfs_count_t wd_cnt_reg;
    logic wd_err;
    logic wd_service_ok;
    logic wd_int_reg;

    logic [NUM_PERIPH-1:0] gate_en_reg;
    logic [NUM_PERIPH-1:0] soft_rst_reg;
    logic lock_gate_reg;
    logic lock_soft_reg;

    logic [2:0] ext_sync_reg;
    logic ext_lvl_reg;
    logic ext_fall;
    logic sw_rst_req;

    logic [`SFS_CAUSE_W-1:0] cause_reg;
    logic [`SFS_CAUSE_W-1:0] cause_new;
    logic warm_req;
    sfs_pkg::sfs_wrst_e wrst_state_reg;
    logic [15:0] wrst_cnt_reg;

    function automatic logic key_ok(input logic [31:0] d);
        return d[31:16] == `SFS_WRITE_KEY;
    endfunction : key_ok

    function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] off);
        return en && (a == off);
    endfunction : wr_hit

    // Bus: one wait state, every access is acknowledged, partial writes ignored.
    assign bus_req = cyc_i && stb_i && !ack_reg;
    assign wr_en = bus_req && we_i && (sel_i == 4'hF);
    assign soft_rst = rst_i || (wrst_state_reg == sfs_pkg::WRST_HOLD);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0000_0000;
        end else if (bus_req && !we_i) begin
            dat_reg <= rdata;
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (adr_i)
            `SFS_OFF_CLK_DET: begin
                rdata[`SFS_CD_DISABLE_BIT] = mcd_disable_reg;
                rdata[`SFS_CD_OSC_OFF_BIT] = osc_off_reg;
                rdata[`SFS_CD_MISSING_BIT] = missing_sts_reg;
            end
            `SFS_OFF_FLAGS: rdata[`SFS_FLAG_W-1:0] = flags_reg;
            `SFS_OFF_RWD_PRD: rdata[15:0] = rwd_prd_reg;
            `SFS_OFF_RWD_CNT: rdata[15:0] = rwd_cnt_reg;
            `SFS_OFF_SHADOW: rdata[`SFS_FLAG_W-1:0] = shadow_reg;
            `SFS_OFF_RST_CAUSE: rdata[`SFS_CAUSE_W-1:0] = cause_reg;
            `SFS_OFF_WD_CTRL: begin
                rdata[`SFS_WD_INT_SEL_BIT] = wd_int_sel_reg;
                rdata[`SFS_WD_EN_BIT] = wd_en_reg;
            end
            `SFS_OFF_WD_WIN: rdata = {wd_hi_reg, wd_lo_reg};
            `SFS_OFF_WD_CNT: rdata[15:0] = wd_cnt_reg;
            `SFS_OFF_CLK_GATE: rdata[NUM_PERIPH-1:0] = gate_en_reg;
            `SFS_OFF_SOFT_RST: rdata[NUM_PERIPH-1:0] = soft_rst_reg;
            `SFS_OFF_LOCK: begin
                rdata[`SFS_LOCK_GATE_BIT] = lock_gate_reg;
                rdata[`SFS_LOCK_SOFT_BIT] = lock_soft_reg;
            end
            default: rdata = 32'h0000_0000;
        endcase
    end

    // Clock detector control; it comes up enabled so a dead reference is caught
    // before software runs.
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            mcd_disable_reg <= 1'b0;
            osc_off_reg <= 1'b0;
        end else if (wr_hit(wr_en, adr_i, `SFS_OFF_CLK_DET) && key_ok(dat_i)) begin
            mcd_disable_reg <= dat_i[`SFS_CD_DISABLE_BIT];
            osc_off_reg <= dat_i[`SFS_CD_OSC_OFF_BIT];
        end
    end

    sfs_mcd #(
        .OSC_EDGES(`SFS_MCD_OSC_EDGES)
    ) u_mcd (
        .clk_i(clk_i),
        .rst_i(soft_rst),
        .osc_i(osc_i),
        .ref_clk_i(ref_clk_i),
        .enable_i(!mcd_disable_reg),
        .osc_off_i(osc_off_reg),
        .missing_o(missing)
    );

    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            missing_d_reg <= 1'b0;
            missing_sts_reg <= 1'b0;
        end else begin
            missing_d_reg <= missing;
            if (missing) begin
                missing_sts_reg <= 1'b1;
            end else if (wr_hit(wr_en, adr_i, `SFS_OFF_CLK_DET) && key_ok(dat_i)
                         && dat_i[`SFS_CD_MISSING_BIT]) begin
                missing_sts_reg <= 1'b0;
            end
        end
    end

    // Fatal flags: a new event in the clearing cycle survives.
    always_comb begin
        flag_set = '0;
        flag_clr = '0;
        flag_set[`SFS_FLAG_CLK_FAIL_BIT] = missing && !missing_d_reg;
        if (wr_hit(wr_en, adr_i, `SFS_OFF_FLAG_FRC)) begin
            flag_set = flag_set | dat_i[`SFS_FLAG_W-1:0];
        end
        if (wr_hit(wr_en, adr_i, `SFS_OFF_FLAG_CLR)) begin
            flag_clr = dat_i[`SFS_FLAG_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
        end
    end

    assign error_status_o = |flags_reg;
    assign fatal_int_o = |flags_reg;

    // Recovery watchdog.
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            rwd_prd_reg <= `SFS_RWD_PRD_RST;
        end else if (wr_hit(wr_en, adr_i, `SFS_OFF_RWD_PRD) && key_ok(dat_i)) begin
            rwd_prd_reg <= dat_i[15:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (soft_rst || !(|flags_reg)) begin
            rwd_cnt_reg <= 16'h0000;
        end else if (!rwd_expire) begin
            rwd_cnt_reg <= rwd_cnt_reg + 16'h0001;
        end
    end

    assign rwd_expire = (|flags_reg) && (rwd_cnt_reg >= rwd_prd_reg);

    // Shadow store survives warm resets; only power-on clears it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shadow_reg <= '0;
        end else if (wrst_state_reg == sfs_pkg::WRST_IDLE && warm_req) begin
            shadow_reg <= flags_reg;
        end
    end

    // Windowed watchdog; a low bound of zero makes it a plain timeout watchdog.
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            wd_int_sel_reg <= 1'b0;
            wd_en_reg <= 1'b1;
            wd_lo_reg <= `SFS_WD_LO_RST;
            wd_hi_reg <= `SFS_WD_HI_RST;
        end else begin
            if (wr_hit(wr_en, adr_i, `SFS_OFF_WD_CTRL) && key_ok(dat_i)) begin
                wd_int_sel_reg <= dat_i[`SFS_WD_INT_SEL_BIT];
                wd_en_reg <= dat_i[`SFS_WD_EN_BIT];
            end
            if (wr_hit(wr_en, adr_i, `SFS_OFF_WD_WIN)) begin
                wd_lo_reg <= dat_i[15:0];
                wd_hi_reg <= dat_i[31:16];
            end
        end
    end

    assign wd_service_ok = wr_hit(wr_en, adr_i, `SFS_OFF_WD_KEY)
                           && (dat_i[15:0] == `SFS_SERVICE_KEY) && (wd_cnt_reg >= wd_lo_reg);
    always_comb begin
        wd_err = 1'b0;
        if (wd_en_reg) begin
            if (wd_cnt_reg >= wd_hi_reg) begin
                wd_err = 1'b1;
            end else if (wr_hit(wr_en, adr_i, `SFS_OFF_WD_KEY) && !wd_service_ok) begin
                wd_err = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (soft_rst || !wd_en_reg || wd_err || wd_service_ok) begin
            wd_cnt_reg <= 16'h0000;
        end else begin
            wd_cnt_reg <= wd_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            wd_int_reg <= 1'b0;
        end else begin
            wd_int_reg <= wd_err && wd_int_sel_reg;
        end
    end

    assign wd_int_o = wd_int_reg;

    // Peripheral clock gates, soft resets and their set-only locks.
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            lock_gate_reg <= 1'b0;
            lock_soft_reg <= 1'b0;
        end else if (wr_hit(wr_en, adr_i, `SFS_OFF_LOCK) && key_ok(dat_i)) begin
            lock_gate_reg <= lock_gate_reg | dat_i[`SFS_LOCK_GATE_BIT];
            lock_soft_reg <= lock_soft_reg | dat_i[`SFS_LOCK_SOFT_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            gate_en_reg <= '0;
        end else if (wr_hit(wr_en, adr_i, `SFS_OFF_CLK_GATE) && key_ok(dat_i)
                     && !lock_gate_reg) begin
            gate_en_reg <= dat_i[NUM_PERIPH-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            soft_rst_reg <= '0;
        end else if (wr_hit(wr_en, adr_i, `SFS_OFF_SOFT_RST) && key_ok(dat_i)
                     && !lock_soft_reg) begin
            soft_rst_reg <= dat_i[NUM_PERIPH-1:0];
        end
    end

    // Each soft reset reaches only its own peripheral.
    assign periph_clk_en_o = gate_en_reg;
    assign periph_rst_o = soft_rst_reg | {NUM_PERIPH{soft_rst}};

    // External warm reset pin: three stages, change accepted when the second and third stages agree.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_sync_reg <= 3'h7;
            ext_lvl_reg <= 1'b1;
        end else begin
            ext_sync_reg <= {ext_sync_reg[1:0], ext_warm_rst_n_i};
            if (ext_sync_reg[1] == ext_sync_reg[2]) begin
                ext_lvl_reg <= ext_sync_reg[2];
            end
        end
    end

    assign ext_fall = (ext_sync_reg[1] == ext_sync_reg[2]) && !ext_sync_reg[2] && ext_lvl_reg;
    assign sw_rst_req = wr_hit(wr_en, adr_i, `SFS_OFF_SW_RST) && key_ok(dat_i);

    always_comb begin
        cause_new = '0;
        cause_new[`SFS_CAUSE_EXT_BIT] = ext_fall;
        cause_new[`SFS_CAUSE_WD_BIT] = wd_err && !wd_int_sel_reg;
        cause_new[`SFS_CAUSE_RWD_BIT] = rwd_expire;
        cause_new[`SFS_CAUSE_SW_BIT] = sw_rst_req;
    end

    // Requests arriving during the hold are dropped; the hold already resets all.
    assign warm_req = |cause_new;

    // Cause bits pile up until software clears them; a new cause beats a clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause_reg <= `SFS_CAUSE_W'(1) << `SFS_CAUSE_POR_BIT;
        end else begin
            cause_reg <= (cause_reg & ~((wr_hit(wr_en, adr_i, `SFS_OFF_RST_CAUSE))
                         ? dat_i[`SFS_CAUSE_W-1:0] : '0))
                         | ((wrst_state_reg == sfs_pkg::WRST_IDLE) ? cause_new : '0);
        end
    end

    // Warm reset sequencer: shadow capture and entry into the hold both happen
    // on the request edge.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wrst_state_reg <= sfs_pkg::WRST_IDLE;
            wrst_cnt_reg <= 16'h0000;
        end else begin
            unique case (wrst_state_reg)
                sfs_pkg::WRST_IDLE: begin
                    wrst_cnt_reg <= 16'h0000;
                    if (warm_req) begin
                        wrst_state_reg <= sfs_pkg::WRST_HOLD;
                    end
                end
                sfs_pkg::WRST_HOLD: begin
                    wrst_cnt_reg <= wrst_cnt_reg + 16'h0001;
                    if (wrst_cnt_reg == WARM_LAST) begin
                        wrst_state_reg <= sfs_pkg::WRST_IDLE;
                    end
                end
            endcase
        end
    end

    assign warm_rst_o = (wrst_state_reg == sfs_pkg::WRST_HOLD);
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

endmodule : sfs_supervisor

/* sfs_map.svh */
/*
 * Register offsets, field positions, reset values, keys and timing counts of the
 * system fault supervisor. Assumes a byte-addressed Wishbone bus with 32-bit data
 * and a 25 MHz system clock.
 */
// How it works
// - Clock detector counts internal oscillator edges.
// - Detector flags only total reference clock loss.
// - Detector enabled at reset, software may disable.
// - Recovery watchdog resets after unrecovered fatal interrupt.
// - Recovery timeout set by writable period register.
// - Shadow flags cleared only by power-on reset.
// - Flags copied to shadow before warm reset.
// - Critical writes need correct upper-half key.
// - Per-peripheral clock gate, gated after reset.
// - Lock bit freezes clock gate configuration.
// - Lock blocks writes; only reset clears lock.
// - Per-peripheral soft reset, released after reset.
// - Status register accumulates reset causes until cleared.
// - Error status pin signals critical internal error.
// - Force bit sets clock-fail flag like real fault.
// - Oscillator-off test fakes lost reference clock.
// - Non-power-on resets triggerable, recorded, correctly scoped.
// - Watchdog service allowed only inside programmed window.
// - Control bit picks watchdog interrupt or reset.
// - Wrong key or expiry triggers watchdog response.
// - Software-raised fatal interrupt drives error status.
`ifndef SFS_MAP_SVH
`define SFS_MAP_SVH

`define SFS_OFF_CLK_DET 8'h00
`define SFS_OFF_FLAGS 8'h04
`define SFS_OFF_FLAG_CLR 8'h08
`define SFS_OFF_FLAG_FRC 8'h0C
`define SFS_OFF_RWD_PRD 8'h10
`define SFS_OFF_RWD_CNT 8'h14
`define SFS_OFF_SHADOW 8'h18
`define SFS_OFF_RST_CAUSE 8'h1C
`define SFS_OFF_WD_CTRL 8'h20
`define SFS_OFF_WD_WIN 8'h24
`define SFS_OFF_WD_KEY 8'h28
`define SFS_OFF_WD_CNT 8'h2C
`define SFS_OFF_CLK_GATE 8'h30
`define SFS_OFF_SOFT_RST 8'h34
`define SFS_OFF_LOCK 8'h38
`define SFS_OFF_SW_RST 8'h3C

`define SFS_WRITE_KEY 16'h5A5A
`define SFS_SERVICE_KEY 16'hA5C3

`define SFS_CD_DISABLE_BIT 0
`define SFS_CD_OSC_OFF_BIT 1
`define SFS_CD_MISSING_BIT 2
`define SFS_FLAG_W 2
`define SFS_FLAG_CLK_FAIL_BIT 0
`define SFS_FLAG_SW_BIT 1
`define SFS_CAUSE_W 5
`define SFS_CAUSE_POR_BIT 0
`define SFS_CAUSE_EXT_BIT 1
`define SFS_CAUSE_WD_BIT 2
`define SFS_CAUSE_RWD_BIT 3
`define SFS_CAUSE_SW_BIT 4
`define SFS_WD_INT_SEL_BIT 0
`define SFS_WD_EN_BIT 1
`define SFS_LOCK_GATE_BIT 0
`define SFS_LOCK_SOFT_BIT 1

`define SFS_RWD_PRD_RST 16'h1000
`define SFS_WD_LO_RST 16'h0000
`define SFS_WD_HI_RST 16'hFFFF
`define SFS_MCD_OSC_EDGES 8'h08

`define SFS_CLK_MHZ 25
`define SFS_WARM_RST_NS 400
`define SFS_WARM_RST_CYC ((`SFS_WARM_RST_NS * `SFS_CLK_MHZ + 999) / 1000)

`endif

/* sfs_pkg.sv */
/*
 * Types shared by the system fault supervisor files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sfs_pkg;

    typedef enum logic {
        WRST_IDLE,
        WRST_HOLD
    } sfs_wrst_e;

    typedef logic [15:0] sfs_count_t;

endpackage : sfs_pkg

/* sfs_mcd.sv */
/*
 * Missing clock detector: measures the reference clock against the internal
 * oscillator. Assumes both arrive as asynchronous pins slower than half clk_i.
 */
`timescale 1ns/1ps
`include "sfs_map.svh"

module sfs_mcd #(
    parameter logic [7:0] OSC_EDGES = `SFS_MCD_OSC_EDGES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Monitored pins
    input wire logic osc_i,
    input wire logic ref_clk_i,
    // Control and result
    input wire logic enable_i,
    input wire logic osc_off_i,
    output logic missing_o
);

    logic [2:0] osc_sync_reg;
    logic [2:0] ref_sync_reg;
    logic ref_lvl_reg;
    logic [7:0] edge_cnt_reg;
    logic osc_rise;
    logic ref_rise;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_sync_reg <= 3'h0;
            ref_sync_reg <= 3'h0;
        end else begin
            osc_sync_reg <= {osc_sync_reg[1:0], osc_i};
            ref_sync_reg <= {ref_sync_reg[1:0], ref_clk_i};
        end
    end

    // A reference change counts only once the second and third stages agree. An
    // oscillator phase may hold for barely one clk_i period, which that filter would
    // swallow, so oscillator rises are taken straight from the last two stages.
    assign osc_rise = osc_sync_reg[1] && !osc_sync_reg[2];
    assign ref_rise = (ref_sync_reg[1] == ref_sync_reg[2]) && ref_sync_reg[2] && !ref_lvl_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_lvl_reg <= 1'b0;
        end else if (ref_sync_reg[1] == ref_sync_reg[2]) begin
            ref_lvl_reg <= ref_sync_reg[2];
        end
    end

    // Only total silence of the reference is caught; a slow but live reference
    // still clears the count, so drift goes unseen by design.
    always_ff @(posedge clk_i) begin
        if (rst_i || !enable_i) begin
            edge_cnt_reg <= 8'h00;
        end else if (ref_rise && !osc_off_i) begin
            edge_cnt_reg <= 8'h00;
        end else if (osc_rise && edge_cnt_reg != OSC_EDGES) begin
            edge_cnt_reg <= edge_cnt_reg + 8'h01;
        end
    end

    assign missing_o = enable_i && (edge_cnt_reg == OSC_EDGES);

endmodule : sfs_mcd

/* sfs_supervisor_properties.sv */
/*
 * Port-level assertions for the fault supervisor.
 * Assumes the 10-cycle warm reset default and a bind onto the top module.
 */
`timescale 1ns/1ps
module sfs_supervisor_properties #(
    parameter int NUM_PERIPH = 8
) (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    // Status and reset outputs
    input wire logic error_status_o,
    input wire logic fatal_int_o,
    input wire logic wd_int_o,
    input wire logic warm_rst_o,
    input wire logic [NUM_PERIPH-1:0] periph_clk_en_o,
    input wire logic [NUM_PERIPH-1:0] periph_rst_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acknowledged");
    a_ack_one_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_err_mirrors: assert property (error_status_o == fatal_int_o)
        else $error("error pin differs from fatal level");
    a_warm_length: assert property ($rose(warm_rst_o) |-> warm_rst_o[*8] ##1 warm_rst_o
        ##1 warm_rst_o ##1 !warm_rst_o)
        else $error("warm reset length wrong");
    a_periph_held: assert property (warm_rst_o && $past(warm_rst_o) |-> &periph_rst_o)
        else $error("peripheral not held in warm reset");
    // Checked during reset itself, so it cannot be disabled by it.
    a_gate_reset: assert property (disable iff (1'b0) $past(rst_i) && rst_i
        |-> periph_clk_en_o == '0 && &periph_rst_o)
        else $error("gates or resets wrong in reset");
    a_wd_pulse: assert property (wd_int_o |=> !wd_int_o)
        else $error("watchdog interrupt not a pulse");
    a_force_err: assert property (ack_o && we_i && adr_i == 8'h0C && sel_i == 4'hF
        && dat_i[0] && !warm_rst_o && !$past(warm_rst_o) |-> error_status_o)
        else $error("force did not raise error pin");
    a_flag_clear: assert property ($fell(error_status_o) |-> (ack_o && we_i
        && adr_i == 8'h08) || warm_rst_o || $past(warm_rst_o))
        else $error("flags dropped without clear");
endmodule : sfs_supervisor_properties

bind sfs_supervisor sfs_supervisor_properties #(.NUM_PERIPH(NUM_PERIPH)) u_props (.*);

/* sfs_monitor.sv */
/*
 * Far side: oscillator, reference clock and an error pin watcher.
 * Assumes the testbench stops the reference clock on request.
 */
`timescale 1ns/1ps
module sfs_monitor (
    // Observed pin
    input wire logic clk_i,
    input wire logic error_status_i,
    // Clock pins
    input wire logic stop_ref_i,
    output logic osc_o,
    output logic ref_clk_o,
    // Error reports seen
    output int err_edges_o = 0
);
    logic err_q = 1'b0;

    initial begin
        osc_o = 1'b0;
        #5 forever #50 osc_o = ~osc_o;
    end

    // A lost reference stands low rather than frozen mid-level.
    initial begin
        ref_clk_o = 1'b0;
        forever #80 ref_clk_o = stop_ref_i ? 1'b0 : ~ref_clk_o;
    end

    always @(posedge clk_i) begin
        err_q <= error_status_i;
        if (error_status_i && !err_q) begin
            err_edges_o <= err_edges_o + 1;
        end
    end
endmodule : sfs_monitor

/* sfs_supervisor_tb.sv */
/*
 * Self-checking bench for the fault supervisor.
 * Assumes default parameters and a single 25 MHz clock.
 */
`timescale 1ns/1ps
module sfs_supervisor_tb;
    logic clk_i;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic ext_n = 1'b1;
    logic stop_ref = 1'b0;
    logic [31:0] dat_o;
    logic ack_o;
    logic osc;
    logic ref_clk;
    logic error_status_o;
    logic wd_int_o;
    logic warm_rst_o;
    logic [7:0] periph_clk_en_o;
    logic [7:0] periph_rst_o;
    logic [31:0] rd;
    int err_edges;
    int mismatches = 0;
    int checks = 0;
    int took;
    int n;
    int wd_pulses = 0;

    sfs_supervisor DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .osc_i(osc), .ref_clk_i(ref_clk), .ext_warm_rst_n_i(ext_n),
        .error_status_o(error_status_o), .fatal_int_o(), .wd_int_o(wd_int_o),
        .warm_rst_o(warm_rst_o), .periph_clk_en_o(periph_clk_en_o),
        .periph_rst_o(periph_rst_o));
    sfs_monitor u_mon (.clk_i(clk_i), .error_status_i(error_status_o),
        .stop_ref_i(stop_ref), .osc_o(osc), .ref_clk_o(ref_clk), .err_edges_o(err_edges));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    always @(posedge clk_i) if (wd_int_o) wd_pulses <= wd_pulses + 1;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        rd = dat_o;
        check(n < 50, 32'h1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    function automatic logic sig(input int w);
        return w == 0 ? error_status_o : w == 1 ? warm_rst_o : w == 2 ? wd_int_o : !warm_rst_o;
    endfunction : sig

    task automatic wait_on(input int w, input int lim);
        took = 0;
        do begin
            @(posedge clk_i);
            took++;
        end while (took < lim && sig(w) !== 1'b1);
    endtask : wait_on

    task automatic t_after_reset;
        wb(0, 8'h1C, 32'h0);
        check(rd, 32'h1);
        wb(0, 8'h00, 32'h0);
        check(rd[0], 32'h0);
        wb(0, 8'h18, 32'h0);
        check(rd, 32'h0);
        wb(0, 8'h40, 32'h0);
        check(rd, 32'h0);
        check(periph_clk_en_o, 32'h0);
        check(periph_rst_o, 32'h0);
    endtask : t_after_reset

    task automatic t_keys;
        wb(1, 8'h30, 32'h0000_00FF);
        check(periph_clk_en_o, 32'h0);
        wb(1, 8'h30, 32'h5A5A_00A5);
        check(periph_clk_en_o, 32'hA5);
        wb(1, 8'h34, 32'h5A5A_0081);
        check(periph_rst_o, 32'h81);
        check(warm_rst_o, 32'h0);
        wb(1, 8'h38, 32'h5A5A_0001);
        wb(1, 8'h30, 32'h5A5A_0000);
        check(periph_clk_en_o, 32'hA5);
        wb(1, 8'h34, 32'h5A5A_0000);
        check(periph_rst_o, 32'h0);
        wb(1, 8'h38, 32'h5A5A_0000);
        wb(1, 8'h30, 32'h5A5A_0000);
        check(periph_clk_en_o, 32'hA5);
    endtask : t_keys

    task automatic t_force;
        wb(1, 8'h0C, 32'h1);
        check(error_status_o, 32'h1);
        wb(0, 8'h04, 32'h0);
        check(rd, 32'h1);
        wb(1, 8'h08, 32'h3);
        check(error_status_o, 32'h0);
        wb(1, 8'h0C, 32'h2);
        check(err_edges, 32'h2);
        wb(1, 8'h08, 32'h3);
    endtask : t_force

    task automatic t_mcd;
        wb(1, 8'h00, 32'h5A5A_0002);
        wait_on(0, 200);
        check(error_status_o, 32'h1);
        wb(0, 8'h00, 32'h0);
        check(rd[2], 32'h1);
        wb(1, 8'h00, 32'h5A5A_0005);
        wb(1, 8'h08, 32'h1);
        stop_ref <= 1'b1;
        wait_on(0, 100);
        check(error_status_o, 32'h0);
        wb(1, 8'h00, 32'h5A5A_0000);
        wait_on(0, 200);
        check(error_status_o, 32'h1);
        stop_ref <= 1'b0;
        wb(1, 8'h00, 32'h5A5A_0004);
        wb(1, 8'h08, 32'h1);
        wait_on(0, 80);
        check(error_status_o, 32'h0);
    endtask : t_mcd

    task automatic t_recovery;
        wb(1, 8'h10, 32'h5A5A_0040);
        wb(1, 8'h0C, 32'h1);
        wait_on(1, 30);
        wb(1, 8'h08, 32'h1);
        wait_on(1, 100);
        check(warm_rst_o, 32'h0);
        wb(1, 8'h0C, 32'h1);
        wait_on(1, 40);
        check(warm_rst_o, 32'h0);
        wait_on(1, 60);
        check(warm_rst_o, 32'h1);
        wait_on(3, 20);
        wb(0, 8'h18, 32'h0);
        check(rd, 32'h1);
        wb(0, 8'h1C, 32'h0);
        check(rd, 32'h9);
        check(periph_clk_en_o, 32'h0);
        wb(1, 8'h30, 32'h5A5A_0003);
        check(periph_clk_en_o, 32'h3);
        wb(1, 8'h1C, 32'h1F);
        wb(0, 8'h1C, 32'h0);
        check(rd, 32'h0);
    endtask : t_recovery

    task automatic t_wd;
        wb(1, 8'h24, 32'h0180_0080);
        wb(1, 8'h20, 32'h5A5A_0003);
        wb(1, 8'h28, 32'h0000_A5C3);
        check(wd_pulses, 32'h1);
        wb(1, 8'h28, 32'h0000_1234);
        check(wd_pulses, 32'h2);
        do wb(0, 8'h2C, 32'h0); while (rd[15:0] < 16'h0090 && n < 50);
        wb(1, 8'h28, 32'h0000_A5C3);
        wait_on(2, 10);
        check(took, 32'hA);
        wb(0, 8'h2C, 32'h0);
        check(rd < 32'h10, 32'h1);
        wait_on(2, 500);
        check(took < 500, 32'h1);
        wb(1, 8'h20, 32'h5A5A_0002);
        check(wd_pulses, 32'h3);
        wb(1, 8'h28, 32'h0000_1234);
        wait_on(1, 10);
        check(warm_rst_o, 32'h1);
        wait_on(3, 20);
        wb(0, 8'h1C, 32'h0);
        check(rd, 32'h4);
    endtask : t_wd

    task automatic t_resets;
        wb(1, 8'h3C, 32'h0);
        wait_on(1, 10);
        check(warm_rst_o, 32'h0);
        wb(1, 8'h3C, 32'h5A5A_0000);
        wait_on(1, 10);
        check(warm_rst_o, 32'h1);
        wait_on(3, 20);
        ext_n <= 1'b0;
        wait_on(1, 30);
        check(warm_rst_o, 32'h1);
        ext_n <= 1'b1;
        wait_on(3, 20);
        wb(0, 8'h1C, 32'h0);
        check(rd, 32'h16);
    endtask : t_resets

    task automatic give_verdict;
        if (mismatches == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // About 1200 cycles are needed; 10000 leaves margin.
    initial begin
        #400000;
        mismatches++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_after_reset();
        t_keys();
        t_force();
        t_mcd();
        t_recovery();
        t_wd();
        t_resets();
        give_verdict();
    end
endmodule : sfs_supervisor_tb
